/* design/sas_defines.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes inclusion by bare name from design files.
 */
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

// Printed offsets are not all multiples of four: they are register indices.
`define SAS_IDX_RESULT_HIGH 24'h3f0074
`define SAS_IDX_RESULT_LOW 24'h3f0075
`define SAS_IDX_CONTROL 24'h3f0076
`define SAS_IDX_IRQ_STATUS 24'h3f0077
`define SAS_IDX_IRQ_MASK 24'h3f0078
`define SAS_IDX_WIDTH 24

`define SAS_CTL_START 0
`define SAS_CTL_SPEED_LO 1
`define SAS_CTL_SPEED_HI 2
`define SAS_CTL_DONE 3
`define SAS_CTL_SEL_LO 4
`define SAS_CTL_SEL_HI 6
`define SAS_CTL_RESET 8'h00

`define SAS_SAR_MIDSCALE 10'h200
`define SAS_SETUP_STEPS 3'h2
`define SAS_BIT_STEPS 3'h4
`define SAS_RESULT_BITS 4'ha

`define SAS_DIV16 5'h10
`define SAS_DIV8 5'h08
`define SAS_DIV4 5'h04
`define SAS_DIV1 5'h01

`endif

/* design/sas_pkg.sv */
/*
 * Types shared by the converter sequencer files.
 * Assumes the defines header is compiled alongside.
 */
package sas_pkg;

   typedef enum logic [1:0] {
      SAS_IDLE,
      SAS_SETUP,
      SAS_RESOLVE
   } sas_state_e;

   // Analog front-end request bundle.
   typedef struct packed {
      logic [2:0] input_sel;
      logic sample;
      logic [9:0] dac_code;
   } sas_analog_s;

   typedef logic [9:0] sas_result_t;

endpackage

/* design/sas_step_divider.sv */
/*
 * Step-clock divider: one-cycle enable every div_i system clocks.
 * Assumes div_i is stable while running; a restart realigns the count.
 */
`timescale 1ns/10ps
`default_nettype none

module sas_step_divider (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run_i,
   input wire logic [4:0] div_i,
   // Output
   output logic step_o
);

   logic [4:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 5'h00;
         step_o <= 1'b0;
      end else if (!run_i) begin
         cnt_q <= 5'h00;
         step_o <= 1'b0;
      end else if (cnt_q + 5'h01 >= div_i) begin
         cnt_q <= 5'h00;
         step_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 5'h01;
         step_o <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* design/sas_sequencer.sv */
/*
 * Successive-approximation converter sequencer with an APB register slave,
 * sticky interrupt status and mask. Assumes an external comparator whose
 * output is asynchronous and is synchronised here before use.
 */
`timescale 1ns/10ps
`default_nettype none

`include "sas_defines.svh"

module sas_sequencer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog front end
   input wire logic cmp_above,
   output sas_pkg::sas_analog_s analog_o,
   // Interrupt
   output logic irq
);

   logic [`SAS_IDX_WIDTH-1:0] idx;
   logic apb_setup;
   logic apb_commit;
   logic wr_ctl;
   logic wr_sts;
   logic wr_msk;
   logic mapped;
   logic [2:0] sel_q;
   logic [1:0] speed_q;
   logic start_q;
   logic done_q;
   logic [1:0] irq_sts_q;
   logic [1:0] irq_msk_q;
   sas_pkg::sas_result_t result_q;
   sas_pkg::sas_result_t sar_q;
   sas_pkg::sas_state_e state_q;
   logic [2:0] step_cnt_q;
   logic [3:0] bit_cnt_q;
   logic [4:0] div;
   logic step;
   logic cmp_meta_q;
   logic cmp_sync_q;
   logic start_evt;
   logic done_evt;
   logic [31:0] rdata;

   assign idx = paddr[`SAS_IDX_WIDTH+1:2];
   // Read data is fetched in the setup cycle, so no access needs a wait state.
   assign apb_setup = psel && !penable;
   // Writes commit only at the access edge, where the master sees pready high.
   assign apb_commit = psel && penable && pready;
   assign mapped = (idx == `SAS_IDX_RESULT_HIGH) || (idx == `SAS_IDX_RESULT_LOW) ||
                   (idx == `SAS_IDX_CONTROL) || (idx == `SAS_IDX_IRQ_STATUS) ||
                   (idx == `SAS_IDX_IRQ_MASK);
   assign wr_ctl = apb_commit && pwrite && (idx == `SAS_IDX_CONTROL);
   assign wr_sts = apb_commit && pwrite && (idx == `SAS_IDX_IRQ_STATUS);
   assign wr_msk = apb_commit && pwrite && (idx == `SAS_IDX_IRQ_MASK);

   // A start request while busy is ignored; the running conversion keeps going.
   assign start_evt = wr_ctl && pwdata[`SAS_CTL_START] && (state_q == sas_pkg::SAS_IDLE);
   assign done_evt = (state_q == sas_pkg::SAS_RESOLVE) && step &&
                     (step_cnt_q == `SAS_BIT_STEPS - 3'h1) && (bit_cnt_q == 4'h0);

   always_comb begin
      case (speed_q)
         2'b00: div = `SAS_DIV16;
         2'b01: div = `SAS_DIV8;
         2'b10: div = `SAS_DIV4;
         default: div = `SAS_DIV1;
      endcase
   end

   sas_step_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run_i(state_q != sas_pkg::SAS_IDLE),
      .div_i(div),
      .step_o(step)
   );

   // Comparator is asynchronous to pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end else begin
         cmp_meta_q <= cmp_above;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   // Channel and speed; held while converting so one channel feeds each result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 3'h0;
         speed_q <= 2'h0;
      end else if (wr_ctl && state_q == sas_pkg::SAS_IDLE) begin
         sel_q <= pwdata[`SAS_CTL_SEL_HI:`SAS_CTL_SEL_LO];
         speed_q <= pwdata[`SAS_CTL_SPEED_HI:`SAS_CTL_SPEED_LO];
      end
   end

   // Start bit and done flag belong to the sequencer only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
         done_q <= 1'b0;
      end else if (start_evt) begin
         start_q <= 1'b1;
         done_q <= 1'b0;
      end else if (done_evt) begin
         start_q <= 1'b0;
         done_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= sas_pkg::SAS_IDLE;
         step_cnt_q <= 3'h0;
         bit_cnt_q <= 4'h0;
         sar_q <= 10'h000;
      end else begin
         case (state_q)
            sas_pkg::SAS_IDLE: begin
               if (start_evt) begin
                  state_q <= sas_pkg::SAS_SETUP;
                  step_cnt_q <= 3'h0;
                  bit_cnt_q <= `SAS_RESULT_BITS - 4'h1;
                  sar_q <= `SAS_SAR_MIDSCALE;
               end
            end
            sas_pkg::SAS_SETUP: begin
               if (step) begin
                  if (step_cnt_q == `SAS_SETUP_STEPS - 3'h1) begin
                     state_q <= sas_pkg::SAS_RESOLVE;
                     step_cnt_q <= 3'h0;
                  end else begin
                     step_cnt_q <= step_cnt_q + 3'h1;
                  end
               end
            end
            sas_pkg::SAS_RESOLVE: begin
               if (step) begin
                  if (step_cnt_q == `SAS_BIT_STEPS - 3'h1) begin
                     step_cnt_q <= 3'h0;
                     // Keep the trial bit if input is above the DAC, try next bit.
                     sar_q[bit_cnt_q] <= cmp_sync_q;
                     if (bit_cnt_q != 4'h0) begin
                        sar_q[bit_cnt_q - 4'h1] <= 1'b1;
                        bit_cnt_q <= bit_cnt_q - 4'h1;
                     end else begin
                        state_q <= sas_pkg::SAS_IDLE;
                     end
                  end else begin
                     step_cnt_q <= step_cnt_q + 3'h1;
                  end
               end
            end
            default: state_q <= sas_pkg::SAS_IDLE;
         endcase
      end
   end

   // No buffering: every finished conversion replaces the held result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= 10'h000;
      end else if (done_evt) begin
         result_q <= {sar_q[9:1], cmp_sync_q};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_o <= '0;
      end else begin
         analog_o.input_sel <= sel_q;
         analog_o.sample <= (state_q == sas_pkg::SAS_SETUP);
         analog_o.dac_code <= sar_q;
      end
   end

   // Bit 0 marks conversion done, bit 1 a start that was ignored while busy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_q <= 2'h0;
         irq_msk_q <= 2'h0;
      end else begin
         irq_sts_q <= (irq_sts_q & ~(wr_sts ? pwdata[1:0] : 2'h0)) |
                      {wr_ctl && pwdata[`SAS_CTL_START] && !start_evt, done_evt};
         if (wr_msk) begin
            irq_msk_q <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_sts_q & irq_msk_q);
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (idx)
         `SAS_IDX_RESULT_HIGH: rdata[7:0] = result_q[9:2];
         `SAS_IDX_RESULT_LOW: rdata[7:6] = result_q[1:0];
         `SAS_IDX_CONTROL: rdata[6:0] = {sel_q, done_q, speed_q, start_q};
         `SAS_IDX_IRQ_STATUS: rdata[1:0] = irq_sts_q;
         `SAS_IDX_IRQ_MASK: rdata[1:0] = irq_msk_q;
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !mapped;
         prdata <= (apb_setup && !pwrite) ? rdata : 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

/* verif/sas_sequencer_assertions.sv */
/* Concurrent checks on the converter sequencer ports.
   Assumes it is bound to the sequencer and the defines header is on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.svh"
module sas_sequencer_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Analog front end and interrupt
   input wire logic cmp_above,
   input wire sas_pkg::sas_analog_s analog_o,
   input wire logic irq
);
   localparam logic [31:0] A_HI = {6'h00, `SAS_IDX_RESULT_HIGH, 2'h0};
   localparam logic [31:0] A_LO = {6'h00, `SAS_IDX_RESULT_LOW, 2'h0};
   localparam logic [31:0] A_CT = {6'h00, `SAS_IDX_CONTROL, 2'h0};
   logic rd;
   logic [5:0] scnt_q;
   assign rd = psel && penable && pready && !pwrite;
   // Counts how long the setup phase keeps the sample request up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         scnt_q <= 6'h00;
      else
         scnt_q <= analog_o.sample ? scnt_q + 6'h01 : 6'h00;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_mid; analog_o.sample |-> analog_o.dac_code == 10'h200; endproperty
   a_mid: assert property (p_mid) else $error("setup trial not mid-scale");
   // The divider starts one cycle after leaving idle: setup is two steps plus one cycle.
   property p_len; $fell(analog_o.sample) |-> scnt_q inside {6'h03, 6'h09, 6'h11, 6'h21}; endproperty
   a_len: assert property (p_len) else $error("setup length wrong");
   property p_sel; analog_o.sample |=> $stable(analog_o.input_sel); endproperty
   a_sel: assert property (p_sel) else $error("channel moved in conversion");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_ctl; rd && paddr == A_CT |-> !(prdata[0] && prdata[3]) && prdata[31:7] == 0; endproperty
   a_ctl: assert property (p_ctl) else $error("start and done both set");
   property p_hi; rd && paddr == A_HI |-> prdata[31:8] == 0; endproperty
   a_hi: assert property (p_hi) else $error("high result too wide");
   property p_lo; rd && paddr == A_LO |-> prdata[31:8] == 0 && prdata[5:0] == 0; endproperty
   a_lo: assert property (p_lo) else $error("low result unused bits set");
endmodule
`default_nettype wire

/* verif/sas_analog_model.sv */
/* Comparator and multiplexer model: each channel holds a fixed level.
   Assumes the sequencer synchronises cmp_above itself. */
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model (
   // From the sequencer
   input wire sas_pkg::sas_analog_s analog_i,
   // To the sequencer
   output logic cmp_above
);
   logic [9:0] level;
   // The level pattern lets the bench predict each channel's result.
   assign level = {{3{analog_i.input_sel}}, 1'b1};
   // An ideal comparator settles at once, so any speed setting gives an exact result here.
   assign cmp_above = level >= analog_i.dac_code;
endmodule
`default_nettype wire

/* verif/sas_sequencer_tb_top.sv */
/* Bench for the converter sequencer: APB register tests against the analog model.
   Assumes the package, defines header and design files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.svh"
module sas_sequencer_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic pready, pslverr, cmp_above, irq, err;
   logic [9:0] lvl;
   sas_pkg::sas_analog_s analog;
   int mismatches = 0, n_compared = 0, n, dv;
   realtime t0;
   localparam logic [31:0] A_HI = {6'h00, `SAS_IDX_RESULT_HIGH, 2'h0};
   localparam logic [31:0] A_LO = {6'h00, `SAS_IDX_RESULT_LOW, 2'h0};
   localparam logic [31:0] A_CT = {6'h00, `SAS_IDX_CONTROL, 2'h0};
   localparam logic [31:0] A_ST = {6'h00, `SAS_IDX_IRQ_STATUS, 2'h0};
   localparam logic [31:0] A_MK = {6'h00, `SAS_IDX_IRQ_MASK, 2'h0};
   always #2 pclk = ~pclk;
   sas_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_above(cmp_above), .analog_o(analog), .irq(irq));
   sas_analog_model u_model (.analog_i(analog), .cmp_above(cmp_above));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20)
         mismatches++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic test_done;
      if (mismatches == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #50000;
      mismatches++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, A_CT, 0);
      chk(q, 32'h0);
      xfer(0, A_MK, 0);
      chk(q, 32'h0);
      xfer(0, 32'h0, 0);
      chk({q[31:1], err}, 32'h1);
      xfer(1, A_MK, 32'h1);
      for (int ch = 0; ch < 8; ch++) begin
         logic [1:0] s;
         s = 2'(ch);
         dv = s == 0 ? 16 : s == 1 ? 8 : s == 2 ? 4 : 1;
         lvl = {3'(ch), 3'(ch), 3'(ch), 1'b1};
         // Setting the done bit in the write must not stick.
         xfer(1, A_CT, {25'h0, 3'(ch), 1'b1, s, 1'b1});
         t0 = $realtime;
         xfer(0, A_CT, 0);
         chk(q, {25'h0, 3'(ch), 1'b0, s, 1'b1});
         if (ch == 0)
            xfer(1, A_CT, 32'h71);
         n = 0;
         while (irq !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
         end
         n = int'(($realtime - t0) / 4.0);
         chk(32'(n >= 42 * dv && n <= 42 * dv + 8), 32'h1);
         xfer(0, A_CT, 0);
         chk(q, {25'h0, 3'(ch), 1'b1, s, 1'b0});
         xfer(0, A_HI, 0);
         chk(q, {24'h0, lvl[9:2]});
         xfer(0, A_LO, 0);
         chk(q, {24'h0, lvl[1:0], 6'h00});
         xfer(0, A_ST, 0);
         chk(q, ch == 0 ? 32'h3 : 32'h1);
         xfer(1, A_ST, 32'h3);
         xfer(1, A_CT, {25'h0, 3'(ch), 4'h0});
         xfer(0, A_CT, 0);
         chk(q, {25'h0, 3'(ch), 4'h8});
         chk({31'h0, irq}, 32'h0);
      end
      xfer(1, A_MK, 32'h0);
      xfer(1, A_CT, 32'h27);
      repeat (100) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      xfer(0, A_ST, 0);
      chk(q, 32'h1);
      xfer(1, A_MK, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      xfer(1, A_ST, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      // A reset in mid-conversion must leave the block idle with its control, status and high result registers cleared.
      xfer(1, A_CT, 32'h51);
      repeat (20) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, A_CT, 0);
      chk(q, 32'h0);
      xfer(0, A_ST, 0);
      chk(q, 32'h0);
      xfer(0, A_HI, 0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
      test_done();
   end
endmodule
bind sas_sequencer sas_sequencer_assertions u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above),
   .analog_o(analog_o), .irq(irq));
`default_nettype wire
